// ===== pfgmux_pkg.sv
/*
 * Constants for the port F / port G alternate function override block.
 * Assumes a 32-bit AXI4-Lite register bus and 8-bit port F, 5-bit port G.
 */
package pfgmux_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PF_DATA = 8'h04;
  localparam logic [7:0] ADDR_PF_DIR  = 8'h08;
  localparam logic [7:0] ADDR_PG_DATA = 8'h0c;
  localparam logic [7:0] ADDR_PG_DIR  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;

  // Control register fields
  localparam int CTRL_LCD_EN_BIT = 0;
  localparam int CTRL_MASK_LSB   = 4;
  localparam int MASK_W          = 4;

  // Status register fields
  localparam int STAT_PF_LSB   = 0;
  localparam int STAT_PG_LSB   = 8;
  localparam int STAT_DBG_BIT  = 16;
  localparam int STAT_TAP_INSTR_SHIFT_STATE = 17;
  localparam int STAT_TAP_DATA_SHIFT_STATE = 18;

  // Port widths and pin positions
  localparam int PF_W    = 8;
  localparam int PG_W    = 5;
  localparam int PF_TDI  = 7;
  localparam int PF_TDO  = 6;
  localparam int PF_TMS  = 5;
  localparam int PF_TCK  = 4;
  localparam int PG_LCD_SEGMENT_LINE_23 = 4;
  localparam int PG_LCD_SEGMENT_LINE_24 = 3;
  localparam int PG_LCD_SEGMENT_LINE_4  = 2;
  localparam int PG_LCD_SEGMENT_LINE_13 = 1;
  localparam int PG_LCD_SEGMENT_LINE_14 = 0;

  // Port mask thresholds
  localparam logic [MASK_W-1:0] MASK_GT_LCD_SEGMENT_LINE_23 = 4'h5;
  localparam logic [MASK_W-1:0] MASK_GT_LCD_SEGMENT_LINE_24 = 4'h6;
  localparam logic [MASK_W-1:0] MASK_GT_LCD_SEGMENT_LINE_13 = 4'h0;

  // Reset values and bus response codes
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== pfgmux_top.sv
/*
 * Port F / port G alternate function override logic with AXI4-Lite registers.
 * Assumes all inputs synchronous to aclk; the TAP controller, converter and
 * LCD driver sit outside and consume the routed signals.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pfgmux_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  debug_port_enable,
  input  wire logic                  tap_instr_shift_state,
  input  wire logic                  tap_data_shift_state,
  input  wire logic                  tap_tdo,
  output logic                       tap_tdi,
  output logic                       tap_tms,
  output logic                       tap_tck,
  input  wire logic [7:0]            portf_pin_in,
  output logic [7:0]                 portf_pin_out,
  output logic [7:0]                 portf_pin_oe,
  output logic [7:0]                 portf_pullup,
  output logic [7:0]                 portf_analog_in,
  input  wire logic [4:0]            portg_pin_in,
  output logic [4:0]                 portg_pin_out,
  output logic [4:0]                 portg_pin_oe,
  output logic [4:0]                 portg_pullup,
  output logic                       timer0_ext_count_input,
  output logic                       timer1_ext_count_input,
  output logic                       lcd_segment_line_23,
  output logic                       lcd_segment_line_24,
  output logic                       lcd_segment_line_4,
  output logic                       lcd_segment_line_13,
  output logic                       lcd_segment_line_14
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pick override value when its enable is set
  function automatic logic ovr(input logic en, input logic val, input logic dflt);
    ovr = en ? val : dflt;
  endfunction

  // Byte register update under lane 0 strobe
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    wr_byte = strb[0] ? d[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                                lcd_enable_q;
  logic [pfgmux_pkg::MASK_W-1:0]       lcd_port_mask_q;
  logic [pfgmux_pkg::PF_W-1:0]         pf_data_q;
  logic [pfgmux_pkg::PF_W-1:0]         pf_dir_q;
  logic [pfgmux_pkg::PG_W-1:0]         pg_data_q;
  logic [pfgmux_pkg::PG_W-1:0]         pg_dir_q;

  logic                                aw_held_q;
  logic [ADDR_W-1:0]                   aw_addr_q;
  logic                                w_held_q;
  logic [31:0]                         w_data_q;
  logic [3:0]                          w_strb_q;
  logic                                do_write;
  logic [31:0]                         status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Override signals

  logic [7:0] pf_pullup_override_enable, pf_pullup_override_value, pf_direction_override_enable, pf_direction_override_value, pf_output_value_override_enable, pf_output_value_override_value, pf_input_enable_override_enable, pf_input_enable_override_value;
  logic [4:0] pg_pullup_override_enable, pg_direction_override_enable, pg_direction_override_value, pg_input_enable_override_enable;
  logic       lcd_gt5, lcd_gt6, lcd_gt0;
  logic [7:0] pf_din;
  logic [4:0] pg_din;

  // Port F overrides from debug enable
  always_comb begin
    pf_pullup_override_enable  = 8'h00;
    pf_pullup_override_value  = 8'h00;
    pf_direction_override_enable  = 8'h00;
    pf_direction_override_value  = 8'h00;
    pf_output_value_override_enable  = 8'h00;
    pf_output_value_override_value  = 8'h00;
    pf_input_enable_override_enable = 8'h00;
    pf_input_enable_override_value = 8'h00;
    pf_pullup_override_enable[pfgmux_pkg::PF_TDI:pfgmux_pkg::PF_TCK]  = {4{debug_port_enable}};
    pf_direction_override_enable[pfgmux_pkg::PF_TDI:pfgmux_pkg::PF_TCK]  = {4{debug_port_enable}};
    pf_input_enable_override_enable[pfgmux_pkg::PF_TDI:pfgmux_pkg::PF_TCK] = {4{debug_port_enable}};
    pf_pullup_override_value[pfgmux_pkg::PF_TDI] = 1'b1;
    pf_pullup_override_value[pfgmux_pkg::PF_TMS] = 1'b1;
    pf_pullup_override_value[pfgmux_pkg::PF_TCK] = 1'b1;
    pf_direction_override_value[pfgmux_pkg::PF_TDO] = tap_instr_shift_state | tap_data_shift_state;
    pf_output_value_override_enable[pfgmux_pkg::PF_TDO] = debug_port_enable;
    pf_output_value_override_value[pfgmux_pkg::PF_TDO] = tap_tdo;
  end

  // Port G overrides from LCD enable and mask
  assign lcd_gt5 = lcd_enable_q & (lcd_port_mask_q > pfgmux_pkg::MASK_GT_LCD_SEGMENT_LINE_23);
  assign lcd_gt6 = lcd_enable_q & (lcd_port_mask_q > pfgmux_pkg::MASK_GT_LCD_SEGMENT_LINE_24);
  assign lcd_gt0 = lcd_enable_q & (lcd_port_mask_q > pfgmux_pkg::MASK_GT_LCD_SEGMENT_LINE_13);

  always_comb begin
    pg_pullup_override_enable = {lcd_gt5, lcd_gt6, lcd_enable_q, lcd_gt0, lcd_gt0};
    pg_direction_override_enable = pg_pullup_override_enable;
    pg_input_enable_override_enable = pg_pullup_override_enable;
    pg_direction_override_value = 5'h00;
    pg_direction_override_value[pfgmux_pkg::PG_LCD_SEGMENT_LINE_23] = 1'b1;
  end

  // Pin drive, pull-up and input enable per port F pin
  always_comb begin
    for (int i = 0; i < pfgmux_pkg::PF_W; i++) begin
      portf_pin_oe[i]  = ovr(pf_direction_override_enable[i], pf_direction_override_value[i], pf_dir_q[i]);
      portf_pin_out[i] = ovr(pf_output_value_override_enable[i], pf_output_value_override_value[i], pf_data_q[i]);
      portf_pullup[i]  = ovr(pf_pullup_override_enable[i], pf_pullup_override_value[i],
                             pf_data_q[i] & ~pf_dir_q[i]);
      pf_din[i]        = portf_pin_in[i] & ovr(pf_input_enable_override_enable[i], pf_input_enable_override_value[i], 1'b1);
    end
  end

  // Pin drive, pull-up and input enable per port G pin
  always_comb begin
    for (int i = 0; i < pfgmux_pkg::PG_W; i++) begin
      portg_pin_oe[i]  = ovr(pg_direction_override_enable[i], pg_direction_override_value[i], pg_dir_q[i]);
      portg_pin_out[i] = pg_data_q[i];
      portg_pullup[i]  = ovr(pg_pullup_override_enable[i], 1'b0, pg_data_q[i] & ~pg_dir_q[i]);
      pg_din[i]        = portg_pin_in[i] & ~pg_input_enable_override_enable[i];
    end
  end

  // Test port taps; test logic outside runs on the routed clock
  assign tap_tdi = portf_pin_in[pfgmux_pkg::PF_TDI] & debug_port_enable;
  assign tap_tms = portf_pin_in[pfgmux_pkg::PF_TMS] & debug_port_enable;
  assign tap_tck = portf_pin_in[pfgmux_pkg::PF_TCK] & debug_port_enable;

  // Converter channels see every pin level
  assign portf_analog_in = portf_pin_in;

  // Timer count sources unless blocked by LCD
  assign timer0_ext_count_input = pg_din[pfgmux_pkg::PG_LCD_SEGMENT_LINE_23];
  assign timer1_ext_count_input = pg_din[pfgmux_pkg::PG_LCD_SEGMENT_LINE_24];

  // Segment lines claim their pins
  assign lcd_segment_line_23 = lcd_gt5;
  assign lcd_segment_line_24 = lcd_gt6;
  assign lcd_segment_line_4  = lcd_enable_q;
  assign lcd_segment_line_13 = lcd_gt0;
  assign lcd_segment_line_14 = lcd_gt0;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_enable_q    <= 1'b0;
      lcd_port_mask_q <= '0;
      pf_data_q       <= pfgmux_pkg::RST_BYTE;
      pf_dir_q        <= pfgmux_pkg::RST_BYTE;
      pg_data_q       <= '0;
      pg_dir_q        <= '0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= pfgmux_pkg::RESP_OKAY;
    end else begin
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= pfgmux_pkg::RESP_OKAY;
        if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_CTRL) begin
          if (w_strb_q[0]) begin
            lcd_enable_q    <= w_data_q[pfgmux_pkg::CTRL_LCD_EN_BIT];
            lcd_port_mask_q <= w_data_q[pfgmux_pkg::CTRL_MASK_LSB +: pfgmux_pkg::MASK_W];
          end
        end else if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_PF_DATA) begin
          pf_data_q <= wr_byte(pf_data_q, w_data_q, w_strb_q);
        end else if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_PF_DIR) begin
          pf_dir_q <= wr_byte(pf_dir_q, w_data_q, w_strb_q);
        end else if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_PG_DATA) begin
          pg_data_q <= 5'(wr_byte({3'h0, pg_data_q}, w_data_q, w_strb_q));
        end else if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_PG_DIR) begin
          pg_dir_q <= 5'(wr_byte({3'h0, pg_dir_q}, w_data_q, w_strb_q));
        end else if (aw_addr_q[7:0] == pfgmux_pkg::ADDR_STATUS) begin
          s_axi_bresp <= pfgmux_pkg::RESP_OKAY;  // Read-only, write ignored
        end else begin
          s_axi_bresp <= pfgmux_pkg::RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  // Live pin and test port state
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pfgmux_pkg::STAT_PF_LSB +: pfgmux_pkg::PF_W] = pf_din;
    status_word[pfgmux_pkg::STAT_PG_LSB +: pfgmux_pkg::PG_W] = pg_din;
    status_word[pfgmux_pkg::STAT_DBG_BIT]  = debug_port_enable;
    status_word[pfgmux_pkg::STAT_TAP_INSTR_SHIFT_STATE] = tap_instr_shift_state;
    status_word[pfgmux_pkg::STAT_TAP_DATA_SHIFT_STATE] = tap_data_shift_state;
  end

  // Read address accept and data return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pfgmux_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pfgmux_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_CTRL) begin
          s_axi_rdata[pfgmux_pkg::CTRL_LCD_EN_BIT] <= lcd_enable_q;
          s_axi_rdata[pfgmux_pkg::CTRL_MASK_LSB +: pfgmux_pkg::MASK_W] <= lcd_port_mask_q;
        end else if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_PF_DATA) begin
          s_axi_rdata[7:0] <= pf_data_q;
        end else if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_PF_DIR) begin
          s_axi_rdata[7:0] <= pf_dir_q;
        end else if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_PG_DATA) begin
          s_axi_rdata[4:0] <= pg_data_q;
        end else if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_PG_DIR) begin
          s_axi_rdata[4:0] <= pg_dir_q;
        end else if (s_axi_araddr[7:0] == pfgmux_pkg::ADDR_STATUS) begin
          s_axi_rdata <= status_word;
        end else begin
          s_axi_rresp <= pfgmux_pkg::RESP_SLVERR;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== pfgmux_monitor.sv
/* Assertion checker for the port F / port G override block.
   Sees only pfgmux_top ports; bound in at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module pfgmux_monitor (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       debug_port_enable,
  input wire logic       tap_instr_shift_state,
  input wire logic       tap_data_shift_state,
  input wire logic       tap_tdo,
  input wire logic       tap_tdi,
  input wire logic       tap_tms,
  input wire logic       tap_tck,
  input wire logic [7:0] portf_pin_in,
  input wire logic [7:0] portf_pin_out,
  input wire logic [7:0] portf_pin_oe,
  input wire logic [7:0] portf_pullup,
  input wire logic [7:0] portf_analog_in,
  input wire logic [4:0] portg_pin_in,
  input wire logic [4:0] portg_pin_oe,
  input wire logic [4:0] portg_pullup,
  input wire logic       timer0_ext_count_input,
  input wire logic       timer1_ext_count_input,
  input wire logic       lcd_segment_line_23,
  input wire logic       lcd_segment_line_24,
  input wire logic       lcd_segment_line_4,
  input wire logic       lcd_segment_line_13,
  input wire logic       lcd_segment_line_14
);
  //////////////////////////////////////////////////////////////////////
  // One clock domain, reset active low
  default clocking mon_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Test port overrides on port F upper half, converter copy, low half stability
  a_dbg_pullups: assert property (debug_port_enable |-> portf_pullup[7:4] == 4'hb)
    else $error("test port pull-ups wrong");
  a_tdo_drive: assert property (debug_port_enable |-> portf_pin_oe[6] == (tap_instr_shift_state | tap_data_shift_state))
    else $error("scan out driver enable wrong");
  a_tdo_data: assert property (debug_port_enable |-> portf_pin_out[6] == tap_tdo)
    else $error("scan out value wrong");
  a_dbg_inputs: assert property (debug_port_enable |-> (portf_pin_oe[7:4] & 4'hb) == 4'h0)
    else $error("test port input driven");
  a_scan_route: assert property ({tap_tdi, tap_tms, tap_tck} == ({portf_pin_in[7], portf_pin_in[5:4]} & {3{debug_port_enable}}))
    else $error("scan inputs misrouted");
  a_analog_copy: assert property (portf_analog_in == portf_pin_in)
    else $error("converter channel mismatch");
  a_low_nibble: assert property (!$rose(s_axi_bvalid) |-> $stable(portf_pin_oe[3:0]) && $stable(portf_pullup[3:0]))
    else $error("low port F bits changed without write");
  // LCD claims on port G
  a_lcd_segment_line_23_claim: assert property (lcd_segment_line_23 |-> portg_pin_oe[4] && !portg_pullup[4] && !timer0_ext_count_input)
    else $error("segment 23 pin state wrong");
  a_lcd_segment_line_24_claim: assert property (lcd_segment_line_24 |-> !portg_pin_oe[3] && !portg_pullup[3] && !timer1_ext_count_input && lcd_segment_line_23)
    else $error("segment 24 pin state wrong");
  a_low_segs: assert property (lcd_segment_line_13 |-> lcd_segment_line_14 && lcd_segment_line_4 && (portg_pin_oe[2:0] | portg_pullup[2:0]) == 3'h0)
    else $error("low segment pins wrong");
  a_timer_gate: assert property ({timer0_ext_count_input, timer1_ext_count_input} == (portg_pin_in[4:3] & ~{lcd_segment_line_23, lcd_segment_line_24}))
    else $error("timer inputs wrong");
  // Main scenarios reached
  c_shift: cover property (debug_port_enable && tap_data_shift_state);
  c_lcd_segment_line_24: cover property (lcd_segment_line_24);
  c_lcd_segment_line_13: cover property (lcd_segment_line_13 && !lcd_segment_line_23);
endmodule
bind pfgmux_top pfgmux_monitor pfgmux_monitor_i (.aclk, .aresetn, .s_axi_bvalid,
  .debug_port_enable, .tap_instr_shift_state, .tap_data_shift_state, .tap_tdo, .tap_tdi,
  .tap_tms, .tap_tck, .portf_pin_in, .portf_pin_out, .portf_pin_oe, .portf_pullup,
  .portf_analog_in, .portg_pin_in, .portg_pin_oe, .portg_pullup, .timer0_ext_count_input,
  .timer1_ext_count_input, .lcd_segment_line_23, .lcd_segment_line_24, .lcd_segment_line_4,
  .lcd_segment_line_13, .lcd_segment_line_14);
`default_nettype wire

// ===== pfgmux_far_end.sv
/* Far-side model: scan tester, LCD glass and analog sources on the pins.
   Bench sets tester levels; device drive wins where its enable is high. */
`timescale 1ns/1ps
`default_nettype none
module pfgmux_far_end (
  input  wire logic       aclk,
  input  wire logic [7:0] portf_pin_out,
  input  wire logic [7:0] portf_pin_oe,
  input  wire logic [7:0] portf_pullup,
  input  wire logic [4:0] portg_pin_out,
  input  wire logic [4:0] portg_pin_oe,
  input  wire logic [4:0] portg_pullup,
  input  wire logic [7:0] ext_f,
  input  wire logic [7:0] ext_f_en,
  input  wire logic [4:0] ext_g,
  input  wire logic [4:0] ext_g_en,
  output logic      [7:0] portf_pin_in,
  output logic      [4:0] portg_pin_in
);
  logic [7:0] flt_q = 8'h55;
  // Unpulled, undriven lines wander every cycle
  always @(posedge aclk) flt_q <= ~flt_q;
  // Device drive, else tester level (scan clock on bit 4), else pull-up or float
  always_comb begin
    portf_pin_in = (portf_pin_oe & portf_pin_out) |
      (~portf_pin_oe & ((ext_f_en & ext_f) | (~ext_f_en & (portf_pullup | flt_q))));
    portg_pin_in = (portg_pin_oe & portg_pin_out) |
      (~portg_pin_oe & ((ext_g_en & ext_g) | (~ext_g_en & (portg_pullup | flt_q[4:0]))));
  end
endmodule
`default_nettype wire

// ===== pfgmux_bench.sv
/* Self-checking bench for pfgmux_top with far-side pin model.
   Assumes pfgmux_pkg and pfgmux_monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pfgmux_bench;
  typedef struct packed {
    logic dbg; logic [1:0] sh; logic tdo; logic [7:0] ctrl, pf_oe, pf_pu, pf_out;
    logic [4:0] pg_oe, pg_pu, seg;
  } pfgmux_row_s;
  logic aclk = 1'b0, aresetn = 1'b0, debug_port_enable = 1'b0, tap_tdo = 1'b0;
  logic tap_instr_shift_state = 1'b0, tap_data_shift_state = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_f = 8'h00;
  logic [4:0] ext_g = 5'h0a;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tap_tdi, tap_tms, tap_tck, timer0_ext_count_input, timer1_ext_count_input;
  logic lcd_segment_line_23, lcd_segment_line_24, lcd_segment_line_4;
  logic lcd_segment_line_13, lcd_segment_line_14;
  logic [7:0] portf_pin_in, portf_pin_out, portf_pin_oe, portf_pullup, portf_analog_in;
  logic [4:0] portg_pin_in, portg_pin_out, portg_pin_oe, portg_pullup;
  int n_fail = 0, num_checks = 0;
  // Port F data 5a dir 0f, port G data 1f dir 0a throughout
  pfgmux_row_s rows [12] = '{
    '{1'b0, 2'd0, 1'b0, 8'h00, 8'h0f, 8'h50, 8'h5a, 5'h0a, 5'h15, 5'h00},
    '{1'b1, 2'd0, 1'b0, 8'h00, 8'h0f, 8'hb0, 8'h1a, 5'h0a, 5'h15, 5'h00},
    '{1'b1, 2'd1, 1'b1, 8'h00, 8'h4f, 8'hb0, 8'h5a, 5'h0a, 5'h15, 5'h00},
    '{1'b1, 2'd2, 1'b0, 8'h00, 8'h4f, 8'hb0, 8'h1a, 5'h0a, 5'h15, 5'h00},
    '{1'b1, 2'd3, 1'b1, 8'h00, 8'h4f, 8'hb0, 8'h5a, 5'h0a, 5'h15, 5'h00},
    '{1'b0, 2'd3, 1'b0, 8'h70, 8'h0f, 8'h50, 8'h5a, 5'h0a, 5'h15, 5'h00},
    '{1'b0, 2'd0, 1'b0, 8'h01, 8'h0f, 8'h50, 8'h5a, 5'h0a, 5'h11, 5'h04},
    '{1'b0, 2'd0, 1'b0, 8'h11, 8'h0f, 8'h50, 8'h5a, 5'h08, 5'h10, 5'h07},
    '{1'b0, 2'd0, 1'b0, 8'h51, 8'h0f, 8'h50, 8'h5a, 5'h08, 5'h10, 5'h07},
    '{1'b0, 2'd0, 1'b0, 8'h61, 8'h0f, 8'h50, 8'h5a, 5'h18, 5'h00, 5'h17},
    '{1'b0, 2'd0, 1'b0, 8'h71, 8'h0f, 8'h50, 8'h5a, 5'h10, 5'h00, 5'h1f},
    '{1'b1, 2'd2, 1'b0, 8'hf1, 8'h4f, 8'hb0, 8'h1a, 5'h10, 5'h00, 5'h1f}};
  //////////////////////////////////////////////////////////////////////
  // Design and far side
  pfgmux_top #(.ADDR_W(8)) pfgmux_top_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .debug_port_enable, .tap_instr_shift_state,
    .tap_data_shift_state, .tap_tdo, .tap_tdi, .tap_tms, .tap_tck, .portf_pin_in,
    .portf_pin_out, .portf_pin_oe, .portf_pullup, .portf_analog_in, .portg_pin_in,
    .portg_pin_out, .portg_pin_oe, .portg_pullup, .timer0_ext_count_input,
    .timer1_ext_count_input, .lcd_segment_line_23, .lcd_segment_line_24,
    .lcd_segment_line_4, .lcd_segment_line_13, .lcd_segment_line_14);
  pfgmux_far_end pfgmux_far_end_i (.aclk, .portf_pin_out, .portf_pin_oe, .portf_pullup,
    .portg_pin_out, .portg_pin_oe, .portg_pullup, .ext_f, .ext_f_en(8'hf0), .ext_g,
    .ext_g_en(5'h1f), .portf_pin_in, .portg_pin_in);
  // Clock, 100 ns period
  always #50 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic close_out();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write: address and data together, response awaited
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (k == 20) begin
      n_fail++;
      close_out();
    end
  endtask
  // Bus read, data taken at the answering edge
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (k == 20) begin
      n_fail++;
      close_out();
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axw(pfgmux_pkg::ADDR_PF_DATA, 32'h5a, r);
    axw(pfgmux_pkg::ADDR_PF_DIR, 32'h0f, r);
    axw(pfgmux_pkg::ADDR_PG_DATA, 32'h1f, r);
    axw(pfgmux_pkg::ADDR_PG_DIR, 32'h0a, r);
    foreach (rows[i]) begin
      @(posedge aclk);
      debug_port_enable <= rows[i].dbg;
      {tap_instr_shift_state, tap_data_shift_state} <= rows[i].sh;
      tap_tdo <= rows[i].tdo;
      ext_f <= 8'(i * 37);
      ext_g <= 5'(i * 11);
      axw(pfgmux_pkg::ADDR_CTRL, {24'h0, rows[i].ctrl}, r);
      @(negedge aclk);
      chk(portf_pin_oe, rows[i].pf_oe);
      chk(portf_pullup, rows[i].pf_pu);
      chk(portf_pin_out, rows[i].pf_out);
      chk(portg_pin_oe, rows[i].pg_oe);
      chk(portg_pullup, rows[i].pg_pu);
      chk({lcd_segment_line_23, lcd_segment_line_24, lcd_segment_line_4,
           lcd_segment_line_13, lcd_segment_line_14}, rows[i].seg);
      chk({timer0_ext_count_input, timer1_ext_count_input},
          portg_pin_in[4:3] & ~rows[i].seg[4:3]);
      chk({tap_tdi, tap_tms, tap_tck},
          {portf_pin_in[7], portf_pin_in[5:4]} & {3{rows[i].dbg}});
      chk(portf_analog_in, portf_pin_in);
    end
    // Unmapped offset, status and control read-back
    axr(8'h18, d, r);
    chk(r, pfgmux_pkg::RESP_SLVERR);
    axw(8'h18, 32'h1, r);
    chk(r, pfgmux_pkg::RESP_SLVERR);
    axr(pfgmux_pkg::ADDR_STATUS, d, r);
    chk({d[18:16], d[12:4]}, 12'h600);
    axr(pfgmux_pkg::ADDR_CTRL, d, r);
    chk(d, 32'hf1);
    // Write with lane 0 strobe clear leaves control unchanged
    s_axi_wstrb <= 4'h0;
    axw(pfgmux_pkg::ADDR_CTRL, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    chk(r, pfgmux_pkg::RESP_OKAY);
    axr(pfgmux_pkg::ADDR_CTRL, d, r);
    chk(d, 32'hf1);
    // Reset mid-run with test port enabled
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(portf_pullup[7:4], 4'hb);
    chk(portg_pin_oe, 5'h00);
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(pfgmux_pkg::ADDR_PF_DATA, d, r);
    chk(d, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
